// >>> core/epc_cmd.v
// Purpose: command decode and status reporting for the encoder parameter channel
// Assumes: a byte deframer on the same clock presents one whole frame per strobe
// Notes: response is a short byte list; status latch keeps the latest fault
`default_nettype none
`include "epc_consts.vh"

module epc_cmd (
   input wire I_CORE_CLK,
   input wire I_RESET_N,
   // one-cycle strobe: a complete received frame
   input wire i_frm_valid,
   input wire [7:0] i_frm_cmd,
   input wire [3:0] i_frm_len,
   input wire [7:0] i_frm_arg0,
   input wire [7:0] i_frm_arg1,
   input wire [7:0] i_frm_arg2,
   input wire i_frm_parity_err,
   input wire i_frm_cksum_err,
   // fault events, each a one-cycle pulse; the fault pulse carries an 8-bit code, the watchdog reset none
   input wire i_fault_valid,
   input wire [7:0] i_fault_code,
   input wire i_wdog_reset,
   input wire [`EPC_POS_W-1:0] i_position,
   input wire [7:0] i_analog,
   input wire [7:0] i_counter_lo,
   input wire i_fld_err_valid,
   input wire [7:0] i_fld_err_code,
   input wire [7:0] i_serial,
   // command execution strobes toward the rest of the device
   output wire o_set_pos,
   output wire o_cnt_inc,
   output wire o_cnt_clr,
   output wire o_fld_req,
   output wire [7:0] o_fld_cmd,
   output wire o_dev_reset,
   output wire o_set_addr,
   output wire o_cfg_if,
   // response bytes
   output reg o_rsp_valid,
   output reg [3:0] o_rsp_len,
   output reg [7:0] o_rsp_b0,
   output reg [7:0] o_rsp_b1,
   output reg [7:0] o_rsp_b2,
   output reg [7:0] o_status
);
   // ----------------------------------------------------------------
   // command classification
   // ----------------------------------------------------------------
   function is_keyed;
      input [7:0] c;
      begin
         is_keyed = (c == `EPC_CMD_SET_POS) | (c == `EPC_CMD_SET_ADDR) |
            (c == `EPC_CMD_CFG_IF) | (c == `EPC_CMD_CHG_CODE);
      end
   endfunction

   // expected data bytes after the command byte, or the unknown marker
   function [3:0] arg_count;
      input [7:0] c;
      begin
         case (c)
            `EPC_CMD_RD_POS, `EPC_CMD_RD_STAT, `EPC_CMD_RD_TYPE,
            `EPC_CMD_RESET, `EPC_CMD_RD_SERIAL, `EPC_CMD_MEM_FREE: arg_count = 4'h0;
            `EPC_CMD_RD_CNT, `EPC_CMD_INC_CNT, `EPC_CMD_CLR_CNT: arg_count = 4'h0;
            `EPC_CMD_RD_ANA, `EPC_CMD_FLD_STAT, `EPC_CMD_SET_ADDR: arg_count = 4'h1;
            `EPC_CMD_RD_DATA, `EPC_CMD_MK_FLD, `EPC_CMD_CFG_IF: arg_count = 4'h2;
            `EPC_CMD_WR_DATA, `EPC_CMD_SET_POS, `EPC_CMD_CHG_CODE: arg_count = 4'h3;
            default: arg_count = `EPC_LEN_UNK;
         endcase
      end
   endfunction

   wire keyed = is_keyed(i_frm_cmd);
   wire [3:0] want = arg_count(i_frm_cmd);
   wire key_ok;
   wire chg_code_ok;

   epc_key_check u_key (
      .i_clk(I_CORE_CLK),
      .i_reset_n(I_RESET_N),
      .i_check(i_frm_valid & keyed),
      .i_key(i_frm_arg0),
      .i_load(chg_code_ok),
      .i_new_key(i_frm_arg2),
      .o_key_ok(key_ok)
   );

   // ----------------------------------------------------------------
   // frame judgement, in priority order
   // ----------------------------------------------------------------
   reg [7:0] frm_err;
   always @* begin
      frm_err = `EPC_ST_OK;
      if (i_frm_parity_err) begin
         frm_err = `EPC_ST_PARITY;
      end else if (i_frm_cksum_err) begin
         frm_err = `EPC_ST_CKSUM;
      end else if (want == `EPC_LEN_UNK) begin
         frm_err = `EPC_ST_UNK_CMD;
      end else if (i_frm_len != want) begin
         frm_err = `EPC_ST_COUNT;
      end else if (keyed && !key_ok) begin
         // a bad key is a wrong access code on code changes, bad argument otherwise
         frm_err = (i_frm_cmd == `EPC_CMD_CHG_CODE) ? `EPC_ST_ACCESS : `EPC_ST_ARG;
      end else if (i_frm_cmd == `EPC_CMD_RD_ANA && i_frm_arg0 != `EPC_ANA_CH_TEMP &&
            i_frm_arg0 != `EPC_ANA_CH_ALT) begin
         frm_err = `EPC_ST_ARG;
      end
   end

   wire good = i_frm_valid & (frm_err == `EPC_ST_OK);
   wire is_cmd_chg = i_frm_cmd == `EPC_CMD_CHG_CODE;
   assign chg_code_ok = good & is_cmd_chg;

   assign o_set_pos = good & (i_frm_cmd == `EPC_CMD_SET_POS);
   assign o_set_addr = good & (i_frm_cmd == `EPC_CMD_SET_ADDR);
   assign o_cfg_if = good & (i_frm_cmd == `EPC_CMD_CFG_IF);
   assign o_cnt_inc = good & (i_frm_cmd == `EPC_CMD_INC_CNT);
   assign o_cnt_clr = good & (i_frm_cmd == `EPC_CMD_CLR_CNT);
   assign o_dev_reset = good & (i_frm_cmd == `EPC_CMD_RESET);
   assign o_fld_req = good & (i_frm_cmd >= `EPC_CMD_RD_DATA) &
      (i_frm_cmd <= `EPC_CMD_MEM_FREE);
   assign o_fld_cmd = i_frm_cmd;

   // ----------------------------------------------------------------
   // status latch
   // ----------------------------------------------------------------
   // holds the latest nonzero code; a read returns it and clears it, but a
   // fault landing in the same cycle as the read is kept
   reg [7:0] next_status;
   always @* begin
      next_status = o_status;
      if (good && i_frm_cmd == `EPC_CMD_RD_STAT) begin
         next_status = `EPC_ST_OK;
      end
      if (i_frm_valid && frm_err != `EPC_ST_OK) begin
         next_status = frm_err;
      end
      if (i_fld_err_valid && i_fld_err_code != `EPC_ST_OK) begin
         next_status = i_fld_err_code;
      end
      if (i_fault_valid && i_fault_code != `EPC_ST_OK) begin
         next_status = i_fault_code;
      end
      if (i_wdog_reset) begin
         next_status = `EPC_ST_WDOG;
      end
   end

   always @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         o_status <= `EPC_ST_OK;
      end else begin
         o_status <= next_status;
      end
   end

   // ----------------------------------------------------------------
   // response builder
   // ----------------------------------------------------------------
   // error frames answer with the error code alone; field commands answer
   // from the data-field logic, so they produce no response here
   reg [3:0] next_len;
   reg [7:0] next_b0;
   reg [7:0] next_b1;
   reg [7:0] next_b2;
   always @* begin
      next_len = 4'h0;
      next_b0 = 8'h00;
      next_b1 = 8'h00;
      next_b2 = 8'h00;
      if (i_frm_valid && frm_err != `EPC_ST_OK) begin
         next_len = 4'h1;
         next_b0 = frm_err;
      end else if (good) begin
         case (i_frm_cmd)
            `EPC_CMD_RD_POS: begin
               next_len = 4'h2;
               next_b0 = {1'b0, i_position[`EPC_POS_W-1:8]};
               next_b1 = i_position[7:0];
            end
            `EPC_CMD_RD_ANA: begin
               next_len = 4'h1;
               next_b0 = i_analog;
            end
            `EPC_CMD_RD_CNT: begin
               next_len = 4'h1;
               next_b0 = i_counter_lo;
            end
            `EPC_CMD_RD_STAT: begin
               next_len = 4'h1;
               next_b0 = o_status;
            end
            `EPC_CMD_RD_TYPE: begin
               next_len = 4'h1;
               next_b0 = `EPC_TYPE_LABEL;
            end
            `EPC_CMD_RD_SERIAL: begin
               next_len = 4'h1;
               next_b0 = i_serial;
            end
            `EPC_CMD_SET_POS, `EPC_CMD_INC_CNT, `EPC_CMD_CLR_CNT, `EPC_CMD_RESET,
            `EPC_CMD_SET_ADDR, `EPC_CMD_CFG_IF, `EPC_CMD_CHG_CODE: begin
               next_len = 4'h1;
               next_b0 = i_frm_cmd;
            end
            default: begin
               next_len = 4'h0;
            end
         endcase
      end
   end

   always @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         o_rsp_valid <= 1'b0;
         o_rsp_len <= 4'h0;
         o_rsp_b0 <= 8'h00;
         o_rsp_b1 <= 8'h00;
         o_rsp_b2 <= 8'h00;
      end else begin
         o_rsp_valid <= next_len != 4'h0;
         o_rsp_len <= next_len;
         o_rsp_b0 <= next_b0;
         o_rsp_b1 <= next_b1;
         o_rsp_b2 <= next_b2;
      end
   end
endmodule
`default_nettype wire

// >>> core/epc_consts.vh
// Purpose: constants for the encoder parameter-channel command interpreter
// Assumes: frames arrive already de-serialised as bytes with parity/checksum flags
// Notes: status codes, command bytes, key default and position width live here only
//
// Summary of operation
// - status code 00h means no fault detected
// - codes 01h..06h report initialization faults
// - after a watchdog-forced reset, status reports 07h
// - frame faults: 09h parity, 0Ah checksum, 0Bh command, 0Ch count, 0Dh argument
// - data faults: 0Eh protected, 0Fh access code, 10h size, 11h address, 12h field
// - 1Fh speed too high, 20h singleturn unreliable, position-class 01h analog
// - 1Ch analog monitor, 1Dh current/RAM, 1Eh temperature, 08h counter overflow
// - decode field commands 4Ah..4Eh and counter commands 46h, 47h, 49h
// - decode 50h status, 52h type, 53h reset, 56h serial/version
// - 43h, 55h, 57h carry a protection key byte that is checked
// - protection key defaults to 55h
// - read position 42h returns a 15-bit absolute position
`ifndef EPC_CONSTS_VH
`define EPC_CONSTS_VH

`define EPC_ST_OK 8'h00
`define EPC_ST_INIT_ALIGN 8'h01
`define EPC_ST_INIT_CKSUM 8'h06
`define EPC_ST_WDOG 8'h07
`define EPC_ST_CNT_OVF 8'h08
`define EPC_ST_PARITY 8'h09
`define EPC_ST_CKSUM 8'h0A
`define EPC_ST_UNK_CMD 8'h0B
`define EPC_ST_COUNT 8'h0C
`define EPC_ST_ARG 8'h0D
`define EPC_ST_PROTECT 8'h0E
`define EPC_ST_ACCESS 8'h0F
`define EPC_ST_SIZE 8'h10
`define EPC_ST_ADDR 8'h11
`define EPC_ST_NOFIELD 8'h12
`define EPC_ST_ANALOG 8'h01
`define EPC_ST_SPEED 8'h1F
`define EPC_ST_SINGLE 8'h20
`define EPC_ST_MONITOR 8'h1C
`define EPC_ST_CURRENT 8'h1D
`define EPC_ST_TEMP 8'h1E

`define EPC_CMD_RD_POS 8'h42
`define EPC_CMD_SET_POS 8'h43
`define EPC_CMD_RD_ANA 8'h44
`define EPC_CMD_RD_CNT 8'h46
`define EPC_CMD_INC_CNT 8'h47
`define EPC_CMD_CLR_CNT 8'h49
`define EPC_CMD_RD_DATA 8'h4A
`define EPC_CMD_WR_DATA 8'h4B
`define EPC_CMD_FLD_STAT 8'h4C
`define EPC_CMD_MK_FLD 8'h4D
`define EPC_CMD_MEM_FREE 8'h4E
`define EPC_CMD_CHG_CODE 8'h4F
`define EPC_CMD_RD_STAT 8'h50
`define EPC_CMD_RD_TYPE 8'h52
`define EPC_CMD_RESET 8'h53
`define EPC_CMD_SET_ADDR 8'h55
`define EPC_CMD_RD_SERIAL 8'h56
`define EPC_CMD_CFG_IF 8'h57

`define EPC_KEY_DEFAULT 8'h55
// arbitrary neutral type label, not any real part's code
`define EPC_TYPE_LABEL 8'h5A
`define EPC_POS_W 15
`define EPC_RSP_MAX 4'h4
// analog read channels that the read-analog command accepts
`define EPC_ANA_CH_TEMP 8'h48
`define EPC_ANA_CH_ALT 8'hF0
// length marker for a command byte that is not decoded
`define EPC_LEN_UNK 4'hF

`endif

// >>> core/epc_key_check.v
// Purpose: protection key store and check for vital-setting commands
// Assumes: key byte given with the command; new key applied on change request
// Notes: key resets to its delivered default
`default_nettype none
`include "epc_consts.vh"

module epc_key_check (
   input wire i_clk,
   input wire i_reset_n,
   input wire i_check,
   input wire [7:0] i_key,
   input wire i_load,
   input wire [7:0] i_new_key,
   output wire o_key_ok
);
   reg [7:0] key;

   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         key <= `EPC_KEY_DEFAULT;
      end else if (i_load) begin
         key <= i_new_key;
      end
   end

   assign o_key_ok = i_check & (i_key == key);
endmodule
`default_nettype wire

// >>> bench/epc_cmd_monitor.sv
// Purpose: concurrent checks on the command interpreter ports
// Assumes: one clock domain, synchronous active-low reset
// Notes: attached by bind from the testbench top file
`default_nettype none
module epc_cmd_monitor (
   input wire logic I_CORE_CLK,
   input wire logic I_RESET_N,
   input wire logic i_frm_valid,
   input wire logic [7:0] i_frm_cmd,
   input wire logic [3:0] i_frm_len,
   input wire logic i_frm_parity_err,
   input wire logic i_frm_cksum_err,
   input wire logic i_fault_valid,
   input wire logic [7:0] i_fault_code,
   input wire logic i_wdog_reset,
   input wire logic i_fld_err_valid,
   input wire logic o_set_pos,
   input wire logic o_dev_reset,
   input wire logic o_rsp_valid,
   input wire logic [7:0] o_rsp_b0,
   input wire logic [7:0] o_status
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (!I_RESET_N);
   wire logic good = i_frm_valid && !i_frm_parity_err && !i_frm_cksum_err;
   wire logic quiet = !i_fault_valid && !i_wdog_reset && !i_fld_err_valid;
   sequence s_rsp(logic [7:0] code);
      ##1 o_rsp_valid && o_rsp_b0 == code;
   endsequence
   a_parity_code: assert property (i_frm_valid && i_frm_parity_err |-> s_rsp(8'h09))
      else $error("parity frame not answered with its code");
   a_cksum_code: assert property (
      i_frm_valid && !i_frm_parity_err && i_frm_cksum_err |-> s_rsp(8'h0A))
      else $error("checksum frame not answered with its code");
   a_unknown_cmd: assert property (good && i_frm_cmd == 8'h45 |-> s_rsp(8'h0B))
      else $error("unknown command not refused");
   a_keyed_strobe: assert property (
      o_set_pos |-> good && i_frm_cmd == 8'h43 && i_frm_len == 4'h3)
      else $error("set position strobe without a sound keyed frame");
   a_reset_cmd: assert property (o_dev_reset |-> good && i_frm_cmd == 8'h53)
      else $error("device reset strobe without its command");
   a_wdog_status: assert property (i_wdog_reset |=> o_status == 8'h07)
      else $error("watchdog reset not reported");
   a_fault_latch: assert property (
      i_fault_valid && !i_wdog_reset && i_fault_code != 8'h00 |=>
      o_status == $past(i_fault_code))
      else $error("fault code not latched");
   a_stat_read: assert property (
      good && quiet && i_frm_cmd == 8'h50 && i_frm_len == 4'h0 |->
      ##1 o_rsp_valid && o_rsp_b0 == $past(o_status) && o_status == 8'h00)
      else $error("status read wrong");
   a_status_holds: assert property (!i_frm_valid && quiet |=> $stable(o_status))
      else $error("status changed without cause");
endmodule
`default_nettype wire

// >>> bench/epc_ctrl_model.sv
// Purpose: drive controller model, sends one frame at a time
// Assumes: frame fields stand for the single cycle of the strobe
// Notes: command, length and argument fields are inverted between frames so stale data never looks valid
`default_nettype none
module epc_ctrl_model (
   input wire logic i_clk,
   output logic o_valid,
   output logic [7:0] o_cmd,
   output logic [3:0] o_len,
   output logic [7:0] o_a0,
   output logic [7:0] o_a1,
   output logic o_perr,
   output logic o_cerr
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {o_valid, o_cmd, o_len, o_a0, o_a1, o_perr, o_cerr} = '0;
   // keyed commands carry the key in the first argument
   task send(input logic [7:0] c, input logic [3:0] n, input logic [7:0] a0, a1,
             input logic pe, ce);
      @(posedge i_clk);
      o_valid <= 1'b1;
      {o_cmd, o_len, o_a0, o_a1, o_perr, o_cerr} <= {c, n, a0, a1, pe, ce};
      @(posedge i_clk);
      o_valid <= 1'b0;
      {o_cmd, o_len, o_a0, o_a1} <= ~{c, n, a0, a1};
   endtask
endmodule
`default_nettype wire

// >>> bench/encoder_param_channel_cmds_test.sv
// Purpose: self-checking bench for the command interpreter
// Assumes: responses come one cycle after the frame strobe
// Notes: strobes are captured at the edge that ends the frame cycle
`default_nettype none
`include "epc_consts.vh"
module encoder_param_channel_cmds_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic I_CORE_CLK = 1'b0;
   logic I_RESET_N = 1'b0;
   logic fv, pe, ce;
   logic [7:0] cmd, a0, a1, st, b0, b1, b2, fc, fcap, strb;
   logic [7:0] nk = 8'h00;
   logic [3:0] len, rl;
   logic i_fault_valid = 1'b0, i_wdog_reset = 1'b0, i_fld_err_valid = 1'b0;
   logic [7:0] i_fault_code = 8'h00, i_fld_err_code = 8'h00;
   logic [14:0] pos = 15'h5A3C;
   logic sp, ci, cc, fr, dr, sa, cf, rv;
   int bad_count = 0, n_checks = 0;
   epc_ctrl_model ctrl (.i_clk(I_CORE_CLK), .o_valid(fv), .o_cmd(cmd), .o_len(len),
      .o_a0(a0), .o_a1(a1), .o_perr(pe), .o_cerr(ce));
   epc_cmd dut (.I_CORE_CLK(I_CORE_CLK), .I_RESET_N(I_RESET_N), .i_frm_valid(fv),
      .i_frm_cmd(cmd), .i_frm_len(len), .i_frm_arg0(a0), .i_frm_arg1(a1),
      .i_frm_arg2(a1), .i_frm_parity_err(pe), .i_frm_cksum_err(ce),
      .i_fault_valid(i_fault_valid), .i_fault_code(i_fault_code),
      .i_wdog_reset(i_wdog_reset), .i_position(pos), .i_analog(8'h19),
      .i_counter_lo(8'h03), .i_fld_err_valid(i_fld_err_valid),
      .i_fld_err_code(i_fld_err_code), .i_serial(8'hC4), .o_set_pos(sp),
      .o_cnt_inc(ci), .o_cnt_clr(cc), .o_fld_req(fr), .o_fld_cmd(fc), .o_dev_reset(dr),
      .o_set_addr(sa), .o_cfg_if(cf), .o_rsp_valid(rv), .o_rsp_len(rl), .o_rsp_b0(b0),
      .o_rsp_b1(b1), .o_rsp_b2(b2), .o_status(st));
   initial forever #12.5 I_CORE_CLK = ~I_CORE_CLK;
   always @(posedge I_CORE_CLK) strb <= {1'b0, sp, ci, cc, fr, dr, sa, cf};
   always @(posedge I_CORE_CLK) fcap <= fc;
   task print_verdict;
      if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk8(input string nm, input logic [7:0] e, g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // er: 0 no answer, 1 answer, 2 answer with first byte checked
   task frm(input logic [7:0] c, input logic [3:0] n, input logic [7:0] k,
            input logic p, s, input logic [1:0] er, input logic [7:0] eb, es);
      logic [3:0] el;
      // only a sound position read answers with two bytes
      el = (er == 2'd0) ? 4'h0 : (c == 8'h42 && !p && !s && n == 4'h0) ? 4'h2 : 4'h1;
      ctrl.send(c, n, k, nk, p, s);
      #1;
      chk8("rsp_valid", {7'h00, |er}, {7'h00, rv});
      chk8("rsp_len", {4'h0, el}, {4'h0, rl});
      chk8("rsp_b2", 8'h00, b2);
      if (er == 2'd2) chk8("rsp_b0", eb, b0);
      chk8("strobes", es, strb);
   endtask
   task pulse(input int k, input logic [7:0] c);
      @(posedge I_CORE_CLK);
      i_fault_valid <= (k == 0);
      i_fld_err_valid <= (k == 1);
      i_wdog_reset <= (k == 2);
      i_fault_code <= c;
      i_fld_err_code <= c;
      @(posedge I_CORE_CLK);
      {i_fault_valid, i_fld_err_valid, i_wdog_reset} <= 3'b000;
      #1;
      chk8("status", c, st);
   endtask
   task t_faults;
      logic [7:0] codes [12] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08,
                                 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20};
      foreach (codes[i]) begin
         pulse(0, codes[i]);
         frm(8'h50, 4'h0, 8'h00, 1'b0, 1'b0, 2'd2, codes[i], 8'h00);
         chk8("status", 8'h00, st);
      end
      pulse(2, 8'h07);
   endtask
   task t_fields;
      logic [3:0] lens [5] = '{4'h2, 4'h3, 4'h1, 4'h2, 4'h0};
      for (int c = 8'h0E; c <= 8'h12; c++) pulse(1, c[7:0]);
      foreach (lens[i]) begin
         frm(8'h4A + i[7:0], lens[i], 8'h00, 1'b0, 1'b0, 2'd0, 8'h00, 8'h08);
         chk8("fld_cmd", 8'h4A + i[7:0], fcap);
      end
      frm(8'h46, 4'h0, 8'h00, 1'b0, 1'b0, 2'd2, 8'h03, 8'h00);
      frm(8'h47, 4'h0, 8'h00, 1'b0, 1'b0, 2'd1, 8'h00, 8'h20);
      frm(8'h49, 4'h0, 8'h00, 1'b0, 1'b0, 2'd1, 8'h00, 8'h10);
   endtask
   task t_errs;
      frm(8'h50, 4'h0, 8'h00, 1'b1, 1'b1, 2'd2, 8'h09, 8'h00);
      frm(8'h43, 4'h3, 8'h55, 1'b0, 1'b1, 2'd2, 8'h0A, 8'h00);
      frm(8'h45, 4'h0, 8'h00, 1'b0, 1'b0, 2'd2, 8'h0B, 8'h00);
      frm(8'h50, 4'h1, 8'h00, 1'b0, 1'b0, 2'd2, 8'h0C, 8'h00);
      frm(8'h44, 4'h1, 8'h00, 1'b0, 1'b0, 2'd2, 8'h0D, 8'h00);
      frm(8'h44, 4'h1, 8'h48, 1'b0, 1'b0, 2'd2, 8'h19, 8'h00);
      frm(8'h44, 4'h1, 8'hF0, 1'b0, 1'b0, 2'd2, 8'h19, 8'h00);
   endtask
   // change the key, prove old and new keys, then restore the delivered key
   task t_code;
      nk = 8'h33;
      frm(8'h4F, 4'h3, 8'h54, 1'b0, 1'b0, 2'd2, 8'h0F, 8'h00);
      chk8("status", 8'h0F, st);
      frm(8'h4F, 4'h3, 8'h55, 1'b0, 1'b0, 2'd2, 8'h4F, 8'h00);
      frm(8'h43, 4'h3, 8'h55, 1'b0, 1'b0, 2'd2, 8'h0D, 8'h00);
      frm(8'h43, 4'h3, 8'h33, 1'b0, 1'b0, 2'd1, 8'h00, 8'h40);
      nk = 8'h55;
      frm(8'h4F, 4'h3, 8'h33, 1'b0, 1'b0, 2'd2, 8'h4F, 8'h00);
      frm(8'h57, 4'h2, 8'h55, 1'b0, 1'b0, 2'd1, 8'h00, 8'h01);
      nk = 8'h00;
   endtask
   task t_keyed;
      frm(8'h43, 4'h3, 8'h54, 1'b0, 1'b0, 2'd2, 8'h0D, 8'h00);
      frm(8'h43, 4'h3, 8'h55, 1'b0, 1'b0, 2'd1, 8'h00, 8'h40);
      frm(8'h55, 4'h1, 8'h55, 1'b0, 1'b0, 2'd1, 8'h00, 8'h02);
      frm(8'h57, 4'h2, 8'h55, 1'b0, 1'b0, 2'd1, 8'h00, 8'h01);
   endtask
   task t_reads;
      frm(8'h42, 4'h0, 8'h00, 1'b0, 1'b0, 2'd2, {1'b0, pos[14:8]}, 8'h00);
      chk8("rsp_b1", pos[7:0], b1);
      frm(8'h52, 4'h0, 8'h00, 1'b0, 1'b0, 2'd2, `EPC_TYPE_LABEL, 8'h00);
      frm(8'h56, 4'h0, 8'h00, 1'b0, 1'b0, 2'd2, 8'hC4, 8'h00);
      frm(8'h53, 4'h0, 8'h00, 1'b0, 1'b0, 2'd1, 8'h00, 8'h04);
   endtask
   initial begin
      #100000;
      bad_count++;
      print_verdict;
   end
   initial begin
      repeat (16) @(posedge I_CORE_CLK);
      I_RESET_N <= 1'b1;
      t_faults;
      t_fields;
      t_errs;
      t_keyed;
      t_reads;
      t_code;
      print_verdict;
   end
endmodule
bind epc_cmd epc_cmd_monitor mon (.I_CORE_CLK(I_CORE_CLK), .I_RESET_N(I_RESET_N),
   .i_frm_valid(i_frm_valid), .i_frm_cmd(i_frm_cmd), .i_frm_len(i_frm_len),
   .i_frm_parity_err(i_frm_parity_err), .i_frm_cksum_err(i_frm_cksum_err),
   .i_fault_valid(i_fault_valid), .i_fault_code(i_fault_code),
   .i_wdog_reset(i_wdog_reset), .i_fld_err_valid(i_fld_err_valid), .o_set_pos(o_set_pos),
   .o_dev_reset(o_dev_reset), .o_rsp_valid(o_rsp_valid), .o_rsp_b0(o_rsp_b0),
   .o_status(o_status));
`default_nettype wire
